// ===== rtc_irq_consts.svh
/*
   rtc_irq_consts.svh - register indices, bit positions and reset values
   of the clock's interrupt and alarm logic.
   Assumes: included by bare name; byte address of a register is four
   times its index.
*/
`ifndef RTC_IRQ_CONSTS_SVH
`define RTC_IRQ_CONSTS_SVH

// register indices (byte address = index * 4)
`define IDX_IRQ_ENABLE     6'h01
`define IDX_IRQ_FLAG       6'h02
`define IDX_SUPPLY_STATUS  6'h03
`define IDX_EVT_STATUS     6'h04
`define IDX_EVT_CLEAR      6'h05
`define IDX_EVT_ENABLE     6'h06
`define IDX_ALARM_BASE     6'h10

// alarm page: seconds, minutes, hours, days, weekdays, months, years
`define ALARM_FIELDS       7
`define ALARM_VALUE_WIDTH  7
`define BIT_FIELD_ENABLE   7

// bit positions shared by enable, flag and event registers
`define BIT_ALARM          0
`define BIT_TIMER          1
`define BIT_SUPPLY_LOW1    2
`define BIT_SUPPLY_LOW2    3
`define BIT_SYS_RESET      4
`define IRQ_SOURCES        5

// reset values
`define IRQ_ENABLE_RESET   5'h00
`define IRQ_FLAG_RESET     5'h00
`define SUPPLY_STAT_RESET  3'h0
`define ALARM_FIELD_RESET  8'h00

// AXI4-Lite responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== rtc_irq_pkg.sv
/*
   rtc_irq_pkg.sv - types carried between the interrupt logic and the
   timekeeping logic around it.
   Assumes: the constants header is compiled alongside.
*/
`include "rtc_irq_consts.svh"

package rtc_irq_pkg;

   // one-cycle events from the countdown, voltage and reset logic
   typedef struct packed {
      logic sys_reset;
      logic supply_low2;
      logic supply_low1;
      logic timer_zero;
   } hw_event_type;

   // current watch values; seconds sit in the lowest bits
   typedef struct packed {
      logic [`ALARM_VALUE_WIDTH-1:0] years;
      logic [`ALARM_VALUE_WIDTH-1:0] months;
      logic [`ALARM_VALUE_WIDTH-1:0] weekdays;
      logic [`ALARM_VALUE_WIDTH-1:0] days;
      logic [`ALARM_VALUE_WIDTH-1:0] hours;
      logic [`ALARM_VALUE_WIDTH-1:0] minutes;
      logic [`ALARM_VALUE_WIDTH-1:0] seconds;
   } watch_type;

endpackage

// ===== alarm_field.sv
/*
   alarm_field.sv - one alarm register with its own enable bit and the
   comparison of its value against one watch field.
   Assumes: write strobe and watch value come from logic on sys_clk.
*/
`timescale 1ns/100ps
`include "rtc_irq_consts.svh"

module alarm_field #(
   parameter int VALUE_WIDTH = `ALARM_VALUE_WIDTH
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   // register access
   input  wire logic                   write_en,
   input  wire logic [7:0]             write_data,
   output logic      [7:0]             field,
   // comparison
   input  wire logic [VALUE_WIDTH-1:0] watch_value,
   output logic                        enabled,
   output logic                        match
);

   // stored alarm value and enable
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         field <= `ALARM_FIELD_RESET;
      end else if (write_en) begin
         field <= write_data;
      end
   end

   // enable and match are registered together, so the and of all fields
   // never sees a fresh enable beside a stale comparison (false alarm edge)
   // a disabled field never blocks the and of all fields
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enabled <= 1'b0;
         match   <= 1'b0;
      end else begin
         enabled <= field[`BIT_FIELD_ENABLE]; // [R05]
         match   <= !field[`BIT_FIELD_ENABLE] ||
                    (field[VALUE_WIDTH-1:0] == watch_value); // [R05] [R06]
      end
   end

endmodule

// ===== rtc_irq_alarm.sv
/*
   rtc_irq_alarm.sv - interrupt logic of the real-time clock: five event
   flags with enables, the alarm comparison, the open-drain interrupt pin,
   a bus-side event status with its own interrupt, and an AXI4-Lite slave.
   Assumes: events and watch values come from logic on sys_clk; the pin
   has an external pull-up; one bus write and one read at a time.
*/
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "rtc_irq_consts.svh"

// What this block does
// [R01] timer flag is set only while the timer interrupt enable is one
// [R02] countdown reaching zero sets the timer flag when enabled
// [R03] timer flag and pin stay until software writes zero to it
// [R04] unused upper bits of enable and flag registers read zero
// [R05] each alarm field has its own enable bit; disabled fields ignored
// [R06] enabled alarm fields are compared with the current watch values
// [R07] first match of all enabled fields sets the alarm flag if enabled
// [R08] alarm flag and pin stay until software writes zero to it
// [R09] alarm flag sets again only on a fresh match, not a lasting one
// [R10] interrupt pin is active low and only ever pulled low
// [R11] five sources, each flag in bits zero to four of flag register
// [R12] supply-low one interrupt gated by its enable, pin follows its flag
// [R13] software clears both supply-low one flag and its status bit
// [R14] enable and flag bits: alarm, timer, low one, low two, reset
// [R15] supply-low two pin follows flag; clearing needs flag and status
// [R16] system-reset pin follows flag; clearing needs flag and status
// [R17] pin low while any flag or supply/reset status bit whose enable bit is one is set, released otherwise
// [R18] writing one to a flag leaves it; only hardware sets it
module rtc_irq_alarm (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      reset_n,
   // AXI4-Lite write address and data
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   // AXI4-Lite write response
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   output logic      [1:0]                s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   input  wire logic [7:0]                s_axi_araddr,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic      [31:0]               s_axi_rdata,
   output logic      [1:0]                s_axi_rresp,
   // timekeeping side
   input  wire rtc_irq_pkg::hw_event_type hw_event,
   input  wire rtc_irq_pkg::watch_type    watch,
   // open-drain interrupt pin and bus interrupt
   output logic                           int_n_out,
   output logic                           int_n_oe,
   output logic                           irq
);
   import rtc_irq_pkg::*;

   localparam int NSRC = `IRQ_SOURCES;

   logic            aw_held;
   logic [5:0]      aw_idx;
   logic            w_held;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   logic            reg_wr;
   logic            lane0_wr;
   logic            wr_mapped;
   logic [5:0]      ar_idx;
   logic [31:0]     next_rdata;
   logic            rd_mapped;
   logic [NSRC-1:0] irq_enable;
   logic [NSRC-1:0] irq_flag;
   logic [2:0]      supply_status;
   logic [NSRC-1:0] evt_status;
   logic [NSRC-1:0] evt_enable;
   logic [NSRC-1:0] raw_event;
   logic [NSRC-1:0] flag_set;
   logic [NSRC-1:0] flag_clr;
   logic [2:0]      status_clr;
   logic [NSRC-1:0] evt_clr;
   logic [NSRC-1:0] pending;
   logic            all_match;
   logic            all_match_prev;
   logic            alarm_event;
   logic [48:0]     watch_bits;
   logic [7:0]      alarm_reg [`ALARM_FIELDS];
   logic [`ALARM_FIELDS-1:0] field_en;
   logic [`ALARM_FIELDS-1:0] field_match;

   // write channel: address and data are taken independently and held
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign reg_wr        = aw_held && w_held && !s_axi_bvalid;
   assign lane0_wr      = reg_wr && w_strb[0];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         aw_idx  <= 6'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_idx  <= s_axi_awaddr[7:2];
      end else if (reg_wr) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (reg_wr) begin
         w_held <= 1'b0;
      end
   end

   // known write targets; anything else is answered with an error
   always_comb begin
      case (aw_idx)
         `IDX_IRQ_ENABLE, `IDX_IRQ_FLAG, `IDX_SUPPLY_STATUS,
         `IDX_EVT_STATUS, `IDX_EVT_CLEAR, `IDX_EVT_ENABLE: wr_mapped = 1'b1;
         default: begin
            wr_mapped = (aw_idx >= `IDX_ALARM_BASE) &&
                        (aw_idx < `IDX_ALARM_BASE + 6'(`ALARM_FIELDS));
         end
      endcase
   end

   // write response follows the cycle in which both halves are held
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (reg_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // interrupt enables; five bits in fixed order
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_enable <= `IRQ_ENABLE_RESET;
      end else if (lane0_wr && aw_idx == `IDX_IRQ_ENABLE) begin
         irq_enable <= w_data[NSRC-1:0]; // [R14]
      end
   end

   // alarm page: one comparator per field
   assign watch_bits = watch;

   genvar gi;
   generate
      for (gi = 0; gi < `ALARM_FIELDS; gi++) begin : g_field
         alarm_field u_field (
            .sys_clk     (sys_clk),
            .reset_n     (reset_n),
            .write_en    (lane0_wr && aw_idx == `IDX_ALARM_BASE + 6'(gi)),
            .write_data  (w_data[7:0]),
            .field       (alarm_reg[gi]),
            .watch_value (watch_bits[gi*`ALARM_VALUE_WIDTH +: `ALARM_VALUE_WIDTH]),
            .enabled     (field_en[gi]),
            .match       (field_match[gi])
         );
      end
   endgenerate

   // no enabled field means no alarm at all
   assign all_match   = (&field_match) && (|field_en); // [R05] [R06]
   // only the rising edge counts, so a lasting match cannot re-arm the flag
   assign alarm_event = all_match && !all_match_prev; // [R07] [R09]

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         all_match_prev <= 1'b0;
      end else begin
         all_match_prev <= all_match;
      end
   end

   // raw events in flag order
   assign raw_event = {hw_event.sys_reset, hw_event.supply_low2,
                       hw_event.supply_low1, hw_event.timer_zero,
                       alarm_event}; // [R11] [R14]

   // a flag is set only by its event while its enable is one
   assign flag_set = raw_event & irq_enable; // [R01] [R02] [R07] [R12]

   // only a written zero clears; a written one changes nothing
   assign flag_clr = (lane0_wr && aw_idx == `IDX_IRQ_FLAG) ?
                     ~w_data[NSRC-1:0] : 5'h00; // [R18]

   // set wins over clear, so an event in the clearing cycle survives
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_flag <= `IRQ_FLAG_RESET;
      end else begin
         irq_flag <= (irq_flag & ~flag_clr) | flag_set; // [R03] [R08] [R18]
      end
   end

   // supply and reset status bits sit at bits four down to two
   assign status_clr = (lane0_wr && aw_idx == `IDX_SUPPLY_STATUS) ?
                       ~w_data[`BIT_SYS_RESET:`BIT_SUPPLY_LOW1] : 3'h0;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         supply_status <= `SUPPLY_STAT_RESET;
      end else begin
         supply_status <= (supply_status & ~status_clr) |
                          raw_event[`BIT_SYS_RESET:`BIT_SUPPLY_LOW1]; // [R15] [R16]
      end
   end

   // voltage and reset sources hold the pin until flag and status are clear
   assign pending = irq_flag | {supply_status, 2'h0}; // [R12] [R13] [R15] [R16]

   // open drain: the pin is only ever pulled low
   assign int_n_out = 1'b0; // [R10]
   assign int_n_oe  = |(pending & irq_enable); // [R17] [R03] [R08]

   // bus-side event status: sticky, write-one-to-clear, set wins
   assign evt_clr = (lane0_wr && aw_idx == `IDX_EVT_CLEAR) ?
                    w_data[NSRC-1:0] : 5'h00;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         evt_status <= 5'h00;
      end else begin
         evt_status <= (evt_status & ~evt_clr) | raw_event;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         evt_enable <= 5'h00;
      end else if (lane0_wr && aw_idx == `IDX_EVT_ENABLE) begin
         evt_enable <= w_data[NSRC-1:0];
      end
   end

   assign irq = |(evt_status & evt_enable);

   // read mux; the clear register is write-only and reads zero
   assign ar_idx = s_axi_araddr[7:2];

   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_mapped  = 1'b1;
      case (ar_idx)
         `IDX_IRQ_ENABLE:    next_rdata[NSRC-1:0] = irq_enable; // [R04]
         `IDX_IRQ_FLAG:      next_rdata[NSRC-1:0] = irq_flag;   // [R04]
         `IDX_SUPPLY_STATUS: next_rdata[NSRC-1:0] = {supply_status, 2'h0};
         `IDX_EVT_STATUS:    next_rdata[NSRC-1:0] = evt_status;
         `IDX_EVT_CLEAR:     next_rdata = 32'h0000_0000;
         `IDX_EVT_ENABLE:    next_rdata[NSRC-1:0] = evt_enable;
         default: begin
            if (ar_idx >= `IDX_ALARM_BASE &&
                ar_idx < `IDX_ALARM_BASE + 6'(`ALARM_FIELDS)) begin
               next_rdata[7:0] = alarm_reg[3'(ar_idx - `IDX_ALARM_BASE)];
            end else begin
               rd_mapped = 1'b0;
            end
         end
      endcase
   end

   // read answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // checks on the block's own outputs and state
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // helper: read of enable or flag register in flight
   logic rd_ctl;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ctl <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_ctl <= (ar_idx == `IDX_IRQ_ENABLE) || (ar_idx == `IDX_IRQ_FLAG);
      end
   end

   sequence s_alarm_rise;
      !all_match ##1 all_match;
   endsequence

   sequence s_alarm_clear_only;
      lane0_wr && aw_idx == `IDX_IRQ_FLAG && !w_data[`BIT_ALARM] &&
      pending == 5'h01 && flag_set == 5'h00;
   endsequence

   property p_timer_needs_enable;
      $rose(irq_flag[`BIT_TIMER]) |-> $past(irq_enable[`BIT_TIMER]);
   endproperty
   a_timer_needs_enable: assert property (p_timer_needs_enable) // [R01]
      else $error("timer flag set while its enable was zero");

   property p_timer_sets;
      hw_event.timer_zero && irq_enable[`BIT_TIMER] |=> irq_flag[`BIT_TIMER];
   endproperty
   a_timer_sets: assert property (p_timer_sets) // [R02]
      else $error("enabled countdown end did not set timer flag");

   property p_timer_holds;
      irq_flag[`BIT_TIMER] && !flag_clr[`BIT_TIMER] |=> irq_flag[`BIT_TIMER];
   endproperty
   a_timer_holds: assert property (p_timer_holds) // [R03]
      else $error("timer flag dropped without a written zero");

   property p_reserved_zero;
      s_axi_rvalid && rd_ctl |-> s_axi_rdata[31:5] == 27'h000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [R04]
      else $error("unused bits of enable or flag read nonzero");

   property p_alarm_sets;
      s_alarm_rise ##0 irq_enable[`BIT_ALARM] |=> irq_flag[`BIT_ALARM];
   endproperty
   a_alarm_sets: assert property (p_alarm_sets) // [R07]
      else $error("first alarm match did not set alarm flag");

   property p_alarm_clear_releases;
      s_alarm_clear_only |=> !int_n_oe ##0 !irq_flag[`BIT_ALARM];
   endproperty
   a_alarm_clear_releases: assert property (p_alarm_clear_releases) // [R08]
      else $error("clearing alarm flag did not release the pin");

   property p_no_rearm_same_match;
      !irq_flag[`BIT_ALARM] && all_match && all_match_prev
         |=> !irq_flag[`BIT_ALARM];
   endproperty
   a_no_rearm_same_match: assert property (p_no_rearm_same_match) // [R09]
      else $error("alarm flag set again during a lasting match");

   property p_pin_low_only;
      int_n_oe |-> !int_n_out;
   endproperty
   a_pin_low_only: assert property (p_pin_low_only) // [R10]
      else $error("interrupt pin driven high");

   property p_supply_low1_pin;
      irq_enable[`BIT_SUPPLY_LOW1] && hw_event.supply_low1
         |=> int_n_oe [*2];
   endproperty
   a_supply_low1_pin: assert property (p_supply_low1_pin) // [R12]
      else $error("supply-low one event did not hold the pin");

   property p_status_holds_pin;
      irq_enable[`BIT_SUPPLY_LOW2] && supply_status[1] && !status_clr[1]
         |=> int_n_oe;
   endproperty
   a_status_holds_pin: assert property (p_status_holds_pin) // [R15]
      else $error("supply-low two status released the pin early");

   property p_reset_flag_pin;
      hw_event.sys_reset && irq_enable[`BIT_SYS_RESET] |=> int_n_oe;
   endproperty
   a_reset_flag_pin: assert property (p_reset_flag_pin) // [R16]
      else $error("enabled reset event did not pull the pin");

   property p_pin_idle;
      irq_flag == 5'h00 && supply_status == 3'h0 |-> !int_n_oe;
   endproperty
   a_pin_idle: assert property (p_pin_idle) // [R17]
      else $error("pin pulled with no flag set");

   property p_only_hw_sets;
      1'b1 |=> ((~$past(irq_flag) & irq_flag & ~$past(flag_set)) == 5'h00);
   endproperty
   a_only_hw_sets: assert property (p_only_hw_sets) // [R18]
      else $error("flag set without a hardware event");

endmodule

// ===== host_irq_pin.sv
/*
   host_irq_pin.sv - host side of the open-drain interrupt line.
   Assumes: a pull-up resistor holds the line high while nobody pulls it.
*/
`timescale 1ns/100ps

module host_irq_pin (
   // pin as driven by the device
   input  wire logic int_n_out,
   input  wire logic int_n_oe,
   // level seen by the host
   output wire logic int_line
);
   // pull-up gives the idle level, so a released pin never shows stale data
   assign int_line = int_n_oe ? int_n_out : 1'b1;
endmodule

// ===== rtc_irq_alarm_test.sv
/*
   rtc_irq_alarm_test.sv - self-checking bench of the interrupt and alarm logic.
   Assumes: AXI4-Lite master tasks below, host pin model, 100 MHz sys_clk.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end

module rtc_irq_alarm_test;
   import rtc_irq_pkg::*;

   logic         sys_clk, reset_n;
   logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [7:0]   s_axi_awaddr, s_axi_araddr;
   logic [31:0]  s_axi_wdata, s_axi_rdata;
   logic [3:0]   s_axi_wstrb;
   logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic         s_axi_rvalid, s_axi_rready;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   hw_event_type hw_event;
   watch_type    watch;
   logic         int_n_out, int_n_oe, irq;
   wire          int_line;
   int           n_mismatch, n_checks, k;

   rtc_irq_alarm dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .hw_event(hw_event),
      .watch(watch), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .irq(irq));

   host_irq_pin host_u (.int_n_out(int_n_out), .int_n_oe(int_n_oe), .int_line(int_line));

   // free-running 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic give_up;
      n_mismatch++;
      $display("BAD bus wait timed out");
      close_out();
   endtask

   // readiness is looked at mid-cycle, so the handshake edge is known before it comes
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(negedge sys_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r  = s_axi_bresp;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            `CHK("bresp", er, r)
            return;
         end
      end
      give_up();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      logic ta;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(negedge sys_clk);
         ta = s_axi_arvalid & s_axi_arready;
         d  = s_axi_rdata;
         r  = s_axi_rresp;
         if (s_axi_rvalid) begin
            @(posedge sys_clk);
            s_axi_rready <= 1'b0;
            `CHK("rdata", ed, d)
            `CHK("rresp", er, r)
            return;
         end
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      give_up();
   endtask

   // one-cycle event pulse on the given source
   task automatic pulse(input int b);
      @(posedge sys_clk);
      hw_event <= hw_event_type'(4'h1 << b);
      @(posedge sys_clk);
      hw_event <= '0;
   endtask

   // pin is open drain: data always low, level comes from the pull-up
   task automatic pin(input logic e);
      @(negedge sys_clk);
      `CHK("int_line", e, int_line)
      `CHK("int_n_out", 1'b0, int_n_out)
   endtask

   initial begin
      reset_n = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00; s_axi_wdata = 32'h0000_0000; hw_event = '0; watch = '0;
      s_axi_wstrb = 4'hF;
      n_mismatch = 0; n_checks = 0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(8'h04, 32'h0000_0000, 2'h0);
      rd(8'h08, 32'h0000_0000, 2'h0);
      pin(1'b1);
      // timer event with its enable off: bus status only, no flag, no pin
      wr(8'h18, 32'h0000_0002, 2'h0);
      pulse(0);
      rd(8'h08, 32'h0000_0000, 2'h0);
      pin(1'b1);
      `CHK("irq", 1'b1, irq)
      rd(8'h10, 32'h0000_0002, 2'h0);
      wr(8'h14, 32'h0000_0002, 2'h0);
      @(negedge sys_clk);
      `CHK("irq", 1'b0, irq)
      rd(8'h10, 32'h0000_0000, 2'h0);
      // unmapped place
      wr(8'hFC, 32'h0000_00FF, 2'h2);
      rd(8'hFC, 32'h0000_0000, 2'h2);
      // unused high bits read zero
      wr(8'h04, 32'h0000_00FF, 2'h0);
      rd(8'h04, 32'h0000_001F, 2'h0);
      // a write with its low byte lane off leaves the enables alone
      s_axi_wstrb <= 4'hE;
      wr(8'h04, 32'h0000_0000, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(8'h04, 32'h0000_001F, 2'h0);
      wr(8'h04, 32'h0000_0002, 2'h0);
      pulse(0);
      pin(1'b0);
      rd(8'h08, 32'h0000_0002, 2'h0);
      wr(8'h08, 32'h0000_00FF, 2'h0);
      rd(8'h08, 32'h0000_0002, 2'h0);
      pin(1'b0);
      wr(8'h08, 32'h0000_0000, 2'h0);
      pin(1'b1);
      // supply-low 1, supply-low 2, system reset: flag and status both hold the pin
      wr(8'h04, 32'h0000_001C, 2'h0);
      for (k = 0; k < 3; k++) begin
         pulse(k + 1);
         rd(8'h08, 32'h0000_0004 << k, 2'h0);
         pin(1'b0);
         wr(8'h08, 32'h0000_0000, 2'h0);
         pin(1'b0);
         wr(8'h0C, 32'h0000_0000, 2'h0);
         pin(1'b1);
      end
      // alarm: seconds field disabled and off-value, minutes enabled at 45
      watch.minutes <= 7'd44;
      wr(8'h40, 32'h0000_0005, 2'h0);
      wr(8'h44, 32'h0000_00AD, 2'h0);
      wr(8'h04, 32'h0000_0001, 2'h0);
      rd(8'h08, 32'h0000_0000, 2'h0);
      @(posedge sys_clk);
      watch.minutes <= 7'd45;
      repeat (3) @(posedge sys_clk);
      rd(8'h08, 32'h0000_0001, 2'h0);
      pin(1'b0);
      wr(8'h08, 32'h0000_0000, 2'h0);
      pin(1'b1);
      rd(8'h08, 32'h0000_0000, 2'h0);
      @(posedge sys_clk);
      watch.minutes <= 7'd46;
      repeat (3) @(posedge sys_clk);
      watch.minutes <= 7'd45;
      repeat (3) @(posedge sys_clk);
      rd(8'h08, 32'h0000_0001, 2'h0);
      pin(1'b0);
      close_out();
   end
endmodule
